// ---- common/asc_defines.vh ----
`ifndef ASC_DEFINES_VH
`define ASC_DEFINES_VH

// Register byte offsets
`define ASC_CTRL_OFS 8'h00
`define ASC_STATUS_OFS 8'h04
`define ASC_MASK_OFS 8'h08
`define ASC_RES_LOW_OFS 8'h0c
`define ASC_RES_HIGH_OFS 8'h10

// Control register fields
`define ASC_CTRL_ENABLE 0
`define ASC_CTRL_START 1
`define ASC_CTRL_AUTO 2
`define ASC_CTRL_LEFT 3
`define ASC_CTRL_DIFF 4
`define ASC_CTRL_PS_LO 5
`define ASC_CTRL_PS_HI 7

// Status and mask fields
`define ASC_ST_DONE 0
`define ASC_ST_BUSY 1

// Reset values
`define ASC_CTRL_RST 8'h00
`define ASC_MASK_RST 1'b0

// Converter clock counts, resolution and first trial code
`define ASC_INIT_CYC 4'hc
`define ASC_SAMPLE_CYC 4'h2
`define ASC_RES_BITS 10
`define ASC_SAR_TOP 10'h200

// Sleep mode encodings
`define ASC_SLEEP_IDLE 2'b00
`define ASC_SLEEP_NOISE 2'b01

`endif

// ---- hw/asc_core.v ----
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "asc_defines.vh"
`default_nettype none

module asc_core (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire sleep_cmd,
    input wire [1:0] sleep_mode,
    input wire cpu_halted,
    input wire other_wake,
    input wire auto_trigger,
    input wire cmp_in,
    output reg cpu_active,
    output reg irq,
    output reg analog_power,
    output reg sample_hold,
    output reg [9:0] dac_code
);

    localparam ST_IDLE = 3'd0;
    localparam ST_INIT = 3'd1;
    localparam ST_SAMPLE = 3'd2;
    localparam ST_SAR = 3'd3;
    localparam ST_FINISH = 3'd4;

    reg [7:0] ctrl;
    reg done_flag;
    reg mask;
    reg [9:0] result;
    reg [2:0] state;
    reg [3:0] cnt;
    reg [3:0] bit_idx;
    reg [7:0] pre_cnt;
    reg first_conv;
    reg halted_d;
    reg cmp_s1;
    reg cmp_s2;
    reg trig_s1;
    reg trig_s2;
    reg trig_s3;

    wire converter_enable;
    wire auto_trigger_enable;
    wire left_adjust_select;
    wire diff_mode;
    wire [2:0] prescale;
    wire [7:0] pre_div;
    wire adc_tick;
    wire trig_rise;
    wire sleep_start;
    wire wr_access;
    wire access;
    wire done_set;
    wire [9:0] raw_code;
    wire result_sign_bit;
    wire [7:0] result_low_byte;
    wire [7:0] result_high_byte;
    wire [9:0] next_sar;
    reg [31:0] next_rdata;
    reg next_err;

    assign converter_enable = ctrl[`ASC_CTRL_ENABLE];
    assign auto_trigger_enable = ctrl[`ASC_CTRL_AUTO];
    assign left_adjust_select = ctrl[`ASC_CTRL_LEFT];
    assign diff_mode = ctrl[`ASC_CTRL_DIFF];
    assign prescale = ctrl[`ASC_CTRL_PS_HI:`ASC_CTRL_PS_LO];
    assign pre_div = 8'h02 << ((prescale == 3'h0) ? 3'h1 : prescale); // Four clocks at least for comparator sync
    assign adc_tick = converter_enable && (pre_cnt == pre_div - 8'h01);
    assign trig_rise = trig_s2 && !trig_s3;
    assign access = psel && penable && !pready;
    assign wr_access = access && pwrite;

    // Halt edge in idle or noise sleep with an idle, enabled converter
    assign sleep_start = cpu_halted && !halted_d && converter_enable && !auto_trigger_enable
        && !ctrl[`ASC_CTRL_START] && state == ST_IDLE
        && (sleep_mode == `ASC_SLEEP_IDLE || sleep_mode == `ASC_SLEEP_NOISE);

    assign done_set = (state == ST_FINISH) && adc_tick;

    // Offset binary from the search becomes two's complement in differential mode
    assign raw_code = diff_mode ? {~dac_code[9], dac_code[8:0]} : dac_code;
    assign result_sign_bit = result[9];
    assign result_high_byte = left_adjust_select ? result[9:2] : {6'h00, result_sign_bit, result[8]};
    assign result_low_byte = left_adjust_select ? {result[1:0], 6'h00} : result[7:0];

    // Successive approximation step per bit
    genvar i;
    generate
        for (i = 0; i < `ASC_RES_BITS; i = i + 1) begin : g_sar
            if (i == `ASC_RES_BITS - 1) begin : g_top
                assign next_sar[i] = (state == ST_SAR && bit_idx == i) ? cmp_s2 : dac_code[i];
            end else begin : g_low
                assign next_sar[i] = (state == ST_SAR && bit_idx == i) ? cmp_s2 :
                    (state == ST_SAR && bit_idx == i + 1) ? 1'b1 : dac_code[i];
            end
        end
    endgenerate

    // Input synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            halted_d <= 1'b0;
        end else begin
            cmp_s1 <= cmp_in;
            cmp_s2 <= cmp_s1;
            trig_s1 <= auto_trigger;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            halted_d <= cpu_halted;
        end
    end

    // Prescaler runs only while enabled, restarts on a trigger
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 8'h00;
        end else if (!converter_enable || adc_tick) begin
            pre_cnt <= 8'h00;
        end else if (auto_trigger_enable && trig_rise && state == ST_IDLE) begin
            pre_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
    end

    // Control register and start flag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `ASC_CTRL_RST;
        end else begin
            if (wr_access && paddr == `ASC_CTRL_OFS) begin
                ctrl <= pwdata[7:0];
                if (!pwdata[`ASC_CTRL_ENABLE]) begin
                    ctrl[`ASC_CTRL_START] <= 1'b0;
                end else if (ctrl[`ASC_CTRL_START]) begin
                    ctrl[`ASC_CTRL_START] <= !done_set;
                end
            end else if (sleep_start) begin
                ctrl[`ASC_CTRL_START] <= 1'b1;
            end else if (auto_trigger_enable && trig_rise && converter_enable && state == ST_IDLE) begin
                ctrl[`ASC_CTRL_START] <= 1'b1;
            end else if (done_set) begin
                ctrl[`ASC_CTRL_START] <= 1'b0;
            end
        end
    end

    // Conversion sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            bit_idx <= 4'h0;
            first_conv <= 1'b1;
            dac_code <= 10'h000;
            sample_hold <= 1'b0;
            result <= 10'h000;
        end else if (!converter_enable) begin
            state <= ST_IDLE;
            cnt <= 4'h0;
            first_conv <= 1'b1;
            sample_hold <= 1'b0;
        end else if (adc_tick) begin
            case (state)
                ST_IDLE: begin
                    if (ctrl[`ASC_CTRL_START]) begin
                        state <= first_conv ? ST_INIT : ST_SAMPLE;
                        sample_hold <= !first_conv;
                        cnt <= 4'h0;
                    end
                end
                ST_INIT: begin
                    if (cnt == `ASC_INIT_CYC - 4'h1) begin
                        state <= ST_SAMPLE;
                        sample_hold <= 1'b1;
                        cnt <= 4'h0;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                ST_SAMPLE: begin
                    if (cnt == `ASC_SAMPLE_CYC - 4'h1) begin
                        state <= ST_SAR;
                        sample_hold <= 1'b0;
                        bit_idx <= 4'h9;
                        dac_code <= `ASC_SAR_TOP;
                    end else begin
                        cnt <= cnt + 4'h1;
                    end
                end
                ST_SAR: begin
                    dac_code <= next_sar;
                    if (bit_idx == 4'h0) begin
                        state <= ST_FINISH;
                    end else begin
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
                ST_FINISH: begin
                    result <= raw_code;
                    first_conv <= 1'b0;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Done flag: set wins over write-one-to-clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_flag <= 1'b0;
            mask <= `ASC_MASK_RST;
        end else begin
            if (done_set) begin
                done_flag <= 1'b1;
            end else if (wr_access && paddr == `ASC_STATUS_OFS && pwdata[`ASC_ST_DONE]) begin
                done_flag <= 1'b0;
            end
            if (wr_access && paddr == `ASC_MASK_OFS) begin
                mask <= pwdata[`ASC_ST_DONE];
            end
        end
    end

    // Interrupt, wake and power outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
            cpu_active <= 1'b1;
            analog_power <= 1'b0;
        end else begin
            irq <= (done_flag || done_set) && mask;
            analog_power <= converter_enable;
            if (irq || other_wake) begin
                cpu_active <= 1'b1;
            end else if (sleep_cmd) begin
                cpu_active <= 1'b0;
            end
        end
    end

    // Read mux
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            `ASC_CTRL_OFS: next_rdata = {24'h00_0000, ctrl};
            `ASC_STATUS_OFS: next_rdata = {30'h0000_0000, state != ST_IDLE, done_flag};
            `ASC_MASK_OFS: next_rdata = {31'h0000_0000, mask};
            `ASC_RES_LOW_OFS: next_rdata = {24'h00_0000, result_low_byte};
            `ASC_RES_HIGH_OFS: next_rdata = {24'h00_0000, result_high_byte};
            default: next_err = 1'b1;
        endcase
    end

    // APB slave with one wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && next_err;
            if (access && !pwrite) begin
                prdata <= next_rdata;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule

`default_nettype wire

// ---- sim/asc_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module asc_src (
    input wire logic [9:0] dac_code,
    input wire logic [9:0] level,
    output logic cmp_in
);
    // Keeps a trial bit while the held level reaches the trial code
    assign cmp_in = level >= dac_code;
endmodule
`default_nettype wire

// ---- sim/asc_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module asc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic sleep_cmd,
    input wire logic other_wake,
    input wire logic cpu_active,
    input wire logic irq,
    input wire logic analog_power,
    input wire logic sample_hold
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence acc_s;
        psel && penable && !pready;
    endsequence
    ready_late_a: assert property (acc_s |=> pready ##1 !pready)
        else $error("pready not a one cycle answer");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    sleep_only_a: assert property ($fell(cpu_active) |-> $past(sleep_cmd))
        else $error("cpu halted without sleep");
    stay_active_a: assert property (cpu_active && !sleep_cmd |=> cpu_active)
        else $error("cpu left active mode");
    wake_up_a: assert property (!cpu_active && (irq || other_wake) |=> cpu_active)
        else $error("cpu not woken");
    irq_hold_a: assert property (irq && !(psel && pwrite) |=> irq)
        else $error("interrupt request lost");
    power_keep_a: assert property ($fell(analog_power) |-> $past(psel && pwrite))
        else $error("converter off without write");
    sample_len_a: assert property ($rose(sample_hold) |-> sample_hold [*4])
        else $error("sample phase short");
endmodule
bind asc_core asc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .sleep_cmd(sleep_cmd), .other_wake(other_wake),
    .cpu_active(cpu_active), .irq(irq), .analog_power(analog_power), .sample_hold(sample_hold));
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "asc_defines.vh"
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sleep_cmd = 1'b0, cpu_halted = 1'b0, other_wake = 1'b0, lf = 1'b0, df = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [1:0] sleep_mode = 2'h0;
    logic [9:0] lvl = 10'h000;
    wire [31:0] prdata;
    wire [9:0] dac_code;
    wire pready, pslverr, cpu_active, irq, analog_power, sample_hold, cmp_in;
    integer n_fail = 0, checks = 0, cyc = 0, i, wt = 0;
    always #2 pclk = ~pclk;
    asc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_cmd(sleep_cmd), .sleep_mode(sleep_mode), .cpu_halted(cpu_halted), .other_wake(other_wake),
        .auto_trigger(1'b0), .cmp_in(cmp_in), .cpu_active(cpu_active), .irq(irq),
        .analog_power(analog_power), .sample_hold(sample_hold), .dac_code(dac_code));
    asc_src u_src (.dac_code(dac_code), .level(lvl), .cmp_in(cmp_in));
    task give_verdict;
        begin
            $display("checks=%0d n_fail=%0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            give_verdict;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            checks = checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Expected register byte from the level, coding and adjustment
    function automatic logic [31:0] mres(input logic hi);
        logic [9:0] r;
        begin
            r = df ? lvl ^ 10'h200 : lvl;
            if (lf) mres = hi ? 32'(r[9:2]) : 32'({r[1:0], 6'h00});
            else mres = hi ? 32'(r[9:8]) : 32'(r[7:0]);
        end
    endfunction
    task wirq;
        integer t;
        begin
            t = 0;
            while (irq !== 1'b1 && t < 500) begin
                @(posedge pclk);
                t = t + 1;
            end
            wt = t;
            chk(irq, 1'b1);
        end
    endtask
    task res;
        begin
            apb(1'b0, `ASC_RES_LOW_OFS, 32'h0000_0000);
            chk(rd, mres(1'b0));
            apb(1'b0, `ASC_RES_HIGH_OFS, 32'h0000_0000);
            chk(rd, mres(1'b1));
            apb(1'b0, `ASC_STATUS_OFS, 32'h0000_0000);
            chk(rd, 32'h0000_0001);
            apb(1'b1, `ASC_MASK_OFS, 32'h0000_0000);
            chk(irq, 1'b0);
            apb(1'b1, `ASC_MASK_OFS, 32'h0000_0001);
            chk(irq, 1'b1);
            apb(1'b1, `ASC_STATUS_OFS, 32'h0000_0001);
            chk(irq, 1'b0);
        end
    endtask
    task sl(input logic [1:0] m, input logic ow, input logic cv);
        begin
            sleep_mode <= m;
            sleep_cmd <= 1'b1;
            @(posedge pclk);
            sleep_cmd <= 1'b0;
            cpu_halted <= 1'b1;
            repeat (2) @(posedge pclk);
            chk(cpu_active, 1'b0);
            if (ow) begin
                other_wake <= 1'b1;
                @(posedge pclk);
                other_wake <= 1'b0;
                repeat (2) @(posedge pclk);
                chk(irq, 1'b0);
            end
            if (!cv) repeat (60) @(posedge pclk);
            else wirq;
            repeat (2) @(posedge pclk);
            cpu_halted <= 1'b0;
            chk({irq, analog_power, cpu_active}, {cv, 2'h3});
        end
    endtask
    initial begin
        void'($urandom(17));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `ASC_CTRL_OFS, 32'h0000_0000);
        chk(rd, `ASC_CTRL_RST);
        apb(1'b0, `ASC_MASK_OFS, 32'h0000_0000);
        chk(rd, `ASC_MASK_RST);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        apb(1'b1, `ASC_MASK_OFS, 32'h0000_0001);
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            lf = 1'($urandom);
            df = i < 2 ? 1'b1 : 1'($urandom);
            lvl <= i == 0 ? 10'h000 : i == 1 ? 10'h3ff : 10'($urandom);
            apb(1'b1, `ASC_CTRL_OFS, {27'h000_0000, df, lf, 3'h3});
            wirq;
            chk(wt > 80, i == 0);
            res;
        end
        $display("test conversions done");
        apb(1'b1, `ASC_CTRL_OFS, {27'h000_0000, df, lf, 3'h1});
        sl(2'h1, 1'b0, 1'b1);
        res;
        sl(2'h0, 1'b1, 1'b1);
        res;
        $display("test sleep done");
        apb(1'b1, `ASC_CTRL_OFS, {27'h000_0000, df, lf, 3'h5});
        sl(2'h1, 1'b1, 1'b0);
        sl(2'h2, 1'b1, 1'b0);
        apb(1'b1, `ASC_CTRL_OFS, 32'h0000_0000);
        chk(analog_power, 1'b0);
        apb(1'b1, `ASC_CTRL_OFS, {27'h000_0000, df, lf, 3'h3});
        wirq;
        chk(wt > 80, 1'b1);
        res;
        $display("test other sleep done");
        give_verdict;
    end
endmodule
`default_nettype wire
